// >>> acc_top.sv
// Purpose: control logic for four analog comparators
// Assumes: comparator outputs arrive raw from analog, synchronised here
// Notes:   pin select bits 7..4 hand pins to comparators 3..0
//
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none

module acc_top
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_resetn,
  input  wire acc_pkg::acc_bus_s     i_bus,
  input  wire logic [3:0]            i_cmp_raw,
  output logic      [7:0]            o_rdata,
  output var acc_pkg::acc_ctrl_s     o_ctrl,
  output logic      [3:0]            o_cmp_power,
  output logic      [3:0]            o_pullup_off,
  output logic                       o_neg_short,
  output logic                       o_dac_on,
  output logic                       o_protect_trig,
  output logic                       o_irq
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  acc_ctrl_s   ctrl_q,  ctrl_d;
  logic [7:0]  psel_q,  psel_d;
  acc_edge_e   edge_q,  edge_d;
  logic [3:0]  pu_q,    pu_d;
  logic [4:0]  st_q,    st_d;
  logic [4:0]  ien_q,   ien_d;
  logic [3:0]  s1_q,    s2_q,   s3_q;
  logic [3:0]  s1_d,    s2_d,   s3_d;
  logic [7:0]  rd_q,    rd_d;
  logic [3:0]  pwr_q,   pwr_d;
  logic [3:0]  puoff_q, puoff_d;
  logic        short_q, short_d;
  logic        dac_q,   dac_d;
  logic        prot_q,  prot_d;
  logic        irq_q,   irq_d;
  logic [3:0]  usable;
  logic [3:0]  rise, fall;
  logic        ev0;

  // write strobe decode
  function automatic logic wr_hit(input acc_bus_s b, input logic [2:0] a);
    return b.wr && (b.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    ctrl_d = ctrl_q;
    psel_d = psel_q;
    edge_d = edge_q;
    pu_d   = pu_q;
    ien_d  = ien_q;
    if (wr_hit(i_bus, ACC_A_CTRL)) begin
      ctrl_d = acc_ctrl_s'(i_bus.wdata);
    end
    if (wr_hit(i_bus, ACC_A_PINSEL)) begin
      psel_d = i_bus.wdata;
    end
    if (wr_hit(i_bus, ACC_A_EDGE)) begin
      edge_d = acc_edge_e'(i_bus.wdata[1:0]);
    end
    if (wr_hit(i_bus, ACC_A_PULLUP)) begin
      pu_d = i_bus.wdata[3:0];
    end
    if (wr_hit(i_bus, ACC_A_IRQ_EN)) begin
      ien_d = i_bus.wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator usability and synchronisers
  always_comb begin
    usable = psel_q[ACC_PS_CMP_HI:ACC_PS_CMP_LO] & ctrl_q.cmp_on;
    // edge code 00 also silences comparator 0
    usable[0] = usable[0] && (edge_q != ACC_EDGE_OFF);
    // two-stage sync then gate off comparators
    s1_d = i_cmp_raw;
    s2_d = s1_q;
    s3_d = s2_q & usable;
    rise = s3_d & ~s3_q;
    fall = s3_q & ~s3_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // events, status and outputs
  always_comb begin
    unique case (edge_q)
      ACC_EDGE_OFF:  ev0 = 1'b0;
      ACC_EDGE_RISE: ev0 = rise[0];
      ACC_EDGE_FALL: ev0 = fall[0];
      ACC_EDGE_BOTH: ev0 = rise[0] | fall[0];
    endcase
    // set wins over clear
    st_d = st_q;
    if (wr_hit(i_bus, ACC_A_IRQ_CLR)) begin
      st_d = st_q & ~i_bus.wdata[4:0];
    end
    st_d = st_d | {ev0, rise | fall};
    irq_d = |(st_d & ien_d);
    prot_d = ev0 && (edge_q != ACC_EDGE_BOTH);
    dac_d  = (edge_q != ACC_EDGE_OFF);
    pwr_d = ctrl_q.cmp_on;
    // edge code 00 also stops comparator 0
    pwr_d[0] = ctrl_q.cmp_on[0] && (edge_q != ACC_EDGE_OFF);
    puoff_d = psel_q[ACC_PS_CMP_HI:ACC_PS_CMP_LO] | ~pu_q;
    short_d = (psel_q[ACC_PS_LSB +: 2] == ACC_PS_CPN);
    rd_d = ACC_ZERO8;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ACC_A_CTRL:    rd_d = ctrl_q;
        ACC_A_PINSEL:  rd_d = psel_q;
        ACC_A_EDGE:    rd_d = {6'h00, edge_q};
        ACC_A_PULLUP:  rd_d = {4'h0, pu_q};
        ACC_A_STATUS:  rd_d = {3'h0, st_q};
        ACC_A_IRQ_EN:  rd_d = {3'h0, ien_q};
        ACC_A_IRQ_CLR: rd_d = ACC_ZERO8;
        ACC_A_CMP_OUT: rd_d = {4'h0, s3_q};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctrl_q  <= acc_ctrl_s'(ACC_CTRL_RST);
      psel_q  <= ACC_PINSEL_RST;
      edge_q  <= acc_edge_e'(ACC_EDGE_RST);
      pu_q    <= '0;
      st_q    <= '0;
      ien_q   <= '0;
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      rd_q    <= ACC_ZERO8;
      pwr_q   <= '0;
      puoff_q <= '1;
      short_q <= 1'b0;
      dac_q   <= 1'b0;
      prot_q  <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      psel_q  <= psel_d;
      edge_q  <= edge_d;
      pu_q    <= pu_d;
      st_q    <= st_d;
      ien_q   <= ien_d;
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      s3_q    <= s3_d;
      rd_q    <= rd_d;
      pwr_q   <= pwr_d;
      puoff_q <= puoff_d;
      short_q <= short_d;
      dac_q   <= dac_d;
      prot_q  <= prot_d;
      irq_q   <= irq_d;
    end
  end

  assign o_rdata        = rd_q;
  assign o_ctrl         = ctrl_q;
  assign o_cmp_power    = pwr_q;
  assign o_pullup_off   = puoff_q;
  assign o_neg_short    = short_q;
  assign o_dac_on       = dac_q;
  assign o_protect_trig = prot_q;
  assign o_irq          = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_ctrl_write;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_hit(i_bus, ACC_A_CTRL) |=> (o_ctrl == $past(i_bus.wdata));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  property p_hyst_reset;
    @(posedge i_ref_clk)
      $rose(i_resetn) |-> (o_ctrl.hyst_en == 4'hf && o_ctrl.cmp_on == 4'h0);
  endproperty
  a_hyst_reset: assert property (p_hyst_reset)
    else $error("wrong control reset value");

  property p_power;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      ##1 ((o_cmp_power[3:1] & ~$past(ctrl_q.cmp_on[3:1])) == 3'h0);
  endproperty
  a_power: assert property (p_power)
    else $error("comparator powered while off");

  property p_short;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (psel_q[3:2] == 2'h2) |=> o_neg_short;
  endproperty
  a_short: assert property (p_short)
    else $error("negative inputs not shorted");

  property p_pullup;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      psel_q[4] |=> o_pullup_off[0];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-high left on shared pin");

  property p_usable;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !psel_q[4] [*2] |=> !s3_q[0];
  endproperty
  a_usable: assert property (p_usable)
    else $error("unselected comparator active");

  property p_dual;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_BOTH) |=> !o_protect_trig;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual edge raised protection");

  property p_sync;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      $rose(i_cmp_raw[1]) ##2 usable[1] |=> s3_q[1];
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync latency wrong");

  property p_pwr0_off;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_OFF) |=> !o_cmp_power[0];
  endproperty
  a_pwr0_off: assert property (p_pwr0_off)
    else $error("comparator 0 powered with edge code off");

  property p_dac_on;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q != ACC_EDGE_OFF) |=> o_dac_on;
  endproperty
  a_dac_on: assert property (p_dac_on)
    else $error("converter off while edge code set");

  property p_dac_off;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_OFF) |=> !o_dac_on;
  endproperty
  a_dac_off: assert property (p_dac_off)
    else $error("converter on with edge code off");

  property p_rise_trig;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_RISE) && rise[0] |=> o_protect_trig;
  endproperty
  a_rise_trig: assert property (p_rise_trig)
    else $error("rising edge missed protection");

  property p_fall_trig;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_FALL) && fall[0] |=> o_protect_trig;
  endproperty
  a_fall_trig: assert property (p_fall_trig)
    else $error("falling edge missed protection");

  property p_both_event;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_q == ACC_EDGE_BOTH) && fall[0] |=> st_q[ACC_ST_EDGE0];
  endproperty
  a_both_event: assert property (p_both_event)
    else $error("dual edge event not flagged");

  property p_event_sticky;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      st_q[ACC_ST_EDGE0] && !wr_hit(i_bus, ACC_A_IRQ_CLR)
        |=> st_q[ACC_ST_EDGE0];
  endproperty
  a_event_sticky: assert property (p_event_sticky)
    else $error("edge event flag lost without clear");

  property p_irq_level;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (|(st_q & ien_q)) && !i_bus.wr |=> o_irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with enabled event");

  property p_off_out;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !ctrl_q.cmp_on[1] |=> !s3_q[1];
  endproperty
  a_off_out: assert property (p_off_out)
    else $error("switched-off comparator output not zero");

  property p_ctrl_hold;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !wr_hit(i_bus, ACC_A_CTRL) |=> $stable(o_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control bits moved without write");

  property p_short_off;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (psel_q[ACC_PS_LSB +: 2] != ACC_PS_CPN) |=> !o_neg_short;
  endproperty
  a_short_off: assert property (p_short_off)
    else $error("negative inputs shorted without select");

  property p_pullup_keep;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      !psel_q[ACC_PS_CMP_LO] && pu_q[0] |=> !o_pullup_off[0];
  endproperty
  a_pullup_keep: assert property (p_pullup_keep)
    else $error("pull-high dropped on unshared pin");
endmodule

`default_nettype wire

// >>> acc_pkg.sv
// Purpose: constants and types for the analog comparator control block
// Assumes: single 125 MHz clock, plain register port, 8-bit registers
// Notes:   register indices below are local choices
//
// Overview of operation
// - one 8-bit control reg: 7..4 hysteresis 3..0, 3..0 on/off 3..0.
// - hysteresis bit at 1 is on, at 0 off; all four reset to 1.
// - on/off bit at 0 powers its comparator down; all reset to 0.
// - pin-select [3:2] at 10 shorts negatives 1..3 to the common pin.
// - a pin given to a comparator input loses its pull-high resistor.
// - four comparators, usable once pin select picks them and their on/off bit is 1; comparator 0 also needs edge code not 00.
// - cmp0 edge 00 off+converter, 01 rise, 10 fall, 11 both, no trip.
`default_nettype none

package acc_pkg;
  localparam int          ACC_NCMP         = 4;
  localparam int          ACC_AW           = 3;
  localparam int          ACC_DW           = 8;
  // register indices
  localparam logic [2:0]  ACC_A_CTRL       = 3'h0;
  localparam logic [2:0]  ACC_A_PINSEL     = 3'h1;
  localparam logic [2:0]  ACC_A_EDGE       = 3'h2;
  localparam logic [2:0]  ACC_A_PULLUP     = 3'h3;
  localparam logic [2:0]  ACC_A_STATUS     = 3'h4;
  localparam logic [2:0]  ACC_A_IRQ_EN     = 3'h5;
  localparam logic [2:0]  ACC_A_IRQ_CLR    = 3'h6;
  localparam logic [2:0]  ACC_A_CMP_OUT    = 3'h7;
  // reset values
  localparam logic [7:0]  ACC_CTRL_RST     = 8'hf0;
  localparam logic [7:0]  ACC_PINSEL_RST   = 8'h00;
  localparam logic [1:0]  ACC_EDGE_RST     = 2'h3;
  localparam logic [7:0]  ACC_ZERO8        = 8'h00;
  // field positions
  localparam int          ACC_HY_LSB       = 4;
  localparam int          ACC_PS_LSB       = 2;
  localparam logic [1:0]  ACC_PS_CPN       = 2'h2;
  localparam int          ACC_PS_CMP_HI    = 7;
  localparam int          ACC_PS_CMP_LO    = 4;
  localparam int          ACC_ST_EDGE0     = 4;

  typedef enum logic [1:0] {
    ACC_EDGE_OFF  = 2'h0,
    ACC_EDGE_RISE = 2'h1,
    ACC_EDGE_FALL = 2'h2,
    ACC_EDGE_BOTH = 2'h3
  } acc_edge_e;

  typedef struct packed {
    logic [3:0] hyst_en;
    logic [3:0] cmp_on;
  } acc_ctrl_s;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_s;
endpackage

`default_nettype wire

// >>> test_analog_comparator_control.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   every scenario is a task that drives and judges, relying on state left by earlier ones
`default_nettype none

module test_analog_comparator_control;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;

  logic            clk;
  logic            rstn;
  acc_bus_s        bus;
  logic [3:0]      raw;
  logic [7:0]      rdata;
  acc_ctrl_s       ctrl;
  logic [3:0]      power;
  logic [3:0]      pu_off;
  logic            short_n;
  logic            dac;
  logic            trig;
  logic            irq;
  int              miscompares;
  int              total_checks;
  int              cycles;
  int              trig_cnt;
  logic [7:0]      rv;

  acc_top DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_bus(bus),
    .i_cmp_raw(raw), .o_rdata(rdata), .o_ctrl(ctrl), .o_cmp_power(power),
    .o_pullup_off(pu_off), .o_neg_short(short_n), .o_dac_on(dac),
    .o_protect_trig(trig), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////
  // clock, hang guard and trigger pulse counter
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (trig === 1'b1) trig_cnt++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd(ACC_A_CTRL, rv);
    chk(rv, 8'hf0);
    chk(ctrl, 8'hf0);
    chk({4'h0, power}, 8'h00);
    chk({7'h00, short_n}, 8'h00);
  endtask
  task automatic t_ctrl;
    wr(ACC_A_CTRL, 8'h5a);
    rd(ACC_A_CTRL, rv);
    chk(rv, 8'h5a);
    chk({4'h0, power}, 8'h0a);
    wr(ACC_A_CTRL, 8'h0f);
    wait_cyc(2);
    chk(ctrl, 8'h0f);
    chk({4'h0, power}, 8'h0f);
  endtask
  task automatic t_pins;
    for (int c = 0; c < 4; c++) begin
      wr(ACC_A_PINSEL, 8'(c << 2));
      wait_cyc(2);
      chk({7'h00, short_n}, {7'h00, c == 2});
    end
    wr(ACC_A_PULLUP, 8'h0f);
    wr(ACC_A_PINSEL, 8'h50);
    wait_cyc(2);
    chk({4'h0, pu_off}, 8'h05);
    rd(ACC_A_PINSEL, rv);
    chk(rv, 8'h50);
    rd(ACC_A_PULLUP, rv);
    chk(rv, 8'h0f);
  endtask
  task automatic t_edge;
    for (int e = 0; e < 4; e++) begin
      wr(ACC_A_EDGE, 8'(e));
      wait_cyc(2);
      chk({7'h00, dac}, {7'h00, e != 0});
      chk({7'h00, power[0]}, {7'h00, e != 0});
    end
    rd(ACC_A_EDGE, rv);
    chk(rv, 8'h03);
  endtask
  task automatic t_trig;
    wr(ACC_A_PINSEL, 8'hf0);
    for (int e = 1; e < 4; e++) begin
      wr(ACC_A_EDGE, 8'(e));
      wait_cyc(4);
      trig_cnt = 0;
      @(posedge clk) raw[1:0] <= 2'h3;
      wait_cyc(8);
      @(posedge clk) raw[1:0] <= 2'h0;
      wait_cyc(8);
      chk(8'(trig_cnt), (e == 3) ? 8'h00 : 8'h01);
    end
  endtask
  task automatic t_irq;
    int n;
    wr(ACC_A_EDGE, 8'h01);
    wr(ACC_A_CTRL, 8'h0d);
    wr(ACC_A_IRQ_EN, 8'h01);
    wr(ACC_A_IRQ_CLR, 8'h1f);
    @(posedge clk) raw <= 4'h3;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      wait_cyc(1);
      n++;
    end
    chk({7'h00, irq}, 8'h01);
    rd(ACC_A_CMP_OUT, rv);
    chk(rv, 8'h01);
    rd(ACC_A_STATUS, rv);
    chk(rv, 8'h11);
    wr(ACC_A_IRQ_EN, 8'h00);
    wait_cyc(2);
    chk({7'h00, irq}, 8'h00);
    wr(ACC_A_IRQ_EN, 8'h01);
    wr(ACC_A_IRQ_CLR, 8'h1f);
    wait_cyc(3);
    chk({7'h00, irq}, 8'h00);
    rd(ACC_A_STATUS, rv);
    chk(rv, 8'h00);
    // software powers every comparator down before sleep
    wr(ACC_A_CTRL, 8'hf0);
    wait_cyc(2);
    chk({4'h0, power}, 8'h00);
    rd(ACC_A_CMP_OUT, rv);
    chk(rv, 8'h00);
  endtask
  task automatic t_rerun;
    @(posedge clk) rstn <= 1'b0;
    wait_cyc(2);
    chk(ctrl, 8'hf0);
    chk({4'h0, power}, 8'h00);
    chk({7'h00, dac}, 8'h00);
    @(posedge clk) rstn <= 1'b1;
    wait_cyc(2);
    chk(ctrl, 8'hf0);
    chk({7'h00, dac}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    trig_cnt = 0;
    rstn = 1'b0;
    raw = 4'h0;
    bus = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_ctrl;
    t_pins;
    t_edge;
    t_trig;
    t_irq;
    t_rerun;
    final_report;
  end
endmodule

`default_nettype wire
